// file: test/atrf_adc_trigger_result_test.sv
// Self-checking bench for the converter trigger and result block.
// Acts as APB master; the source model stands for peripherals and converter.
`timescale 1ns/100ps
module atrf_adc_trigger_result_test;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdData;
    logic        pready, pslverr, convStart, convDone, irq, j;
    logic [9:0]  conversionResult;
    logic [9:0]  res = 10'h000;
    logic [12:0] srcLines;
    int          n_fail = 0, n_tests = 0, nStart = 0, cycles = 0;
    atrf_adc_trigger_result atrf_adc_trigger_result_inst (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .captureUnitOne(srcLines[0]), .captureUnitTwo(srcLines[1]), .timerZeroRollover(srcLines[2]),
        .timerOneRollover(srcLines[3]), .timerTwoPeriodHit(srcLines[4]),
        .comparatorOneSyncedOut(srcLines[5]), .comparatorTwoSyncedOut(srcLines[6]),
        .logicCellOneOutput(srcLines[7]), .logicCellTwoOutput(srcLines[8]),
        .logicCellThreeOutput(srcLines[9]), .logicCellFourOutput(srcLines[10]),
        .timerFourPeriodHit(srcLines[11]), .timerSixPeriodHit(srcLines[12]), .convStart(convStart),
        .convDone(convDone), .conversionResult(conversionResult), .irq(irq));
    atrf_source_model atrf_source_model_inst (.mclk(mclk), .sys_rst(sys_rst), .srcLines(srcLines),
        .convStart(convStart), .resultIn(res), .convDone(convDone), .conversionResult(conversionResult));
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (convStart === 1'b1) nStart++;
        if (cycles == 20000) begin
            n_fail++;
            $display("CHECK FAILED %0t timeout", $time);
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && cycles < 20000);
        rdData = prdata;
        j = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdData, e);
    endtask
    task automatic wait_idle(input logic [31:0] e);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h0C, 32'h0);
            n++;
        end while (rdData[0] !== 1'b0 && n < 40);
        chk(rdData, e);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'hDF);
        rd(8'h00, 32'hD0);
        apb(1'b1, 8'h04, 32'h5A);
        apb(1'b1, 8'h08, 32'hC3);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(8'h04, 32'h5A);
        rd(8'h08, 32'hC3);
        rd(8'h1C, 32'h0);
        chk({31'h0, j}, 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        for (int c = 1; c <= 13; c++) begin
            res <= {c[3:0], 6'h15};
            apb(1'b1, 8'h00, {24'h0, c[3:0], 4'h0});
            apb(1'b1, 8'h0C, {24'h0, c[0], 7'h0});
            repeat (20) @(posedge mclk);
            atrf_source_model_inst.pulse(c - 1, 10);
            wait_idle({24'h0, c[0], 7'h0});
            chk(nStart, c);
            rd(8'h04, c[0] ? {30'h0, res[9:8]} : {24'h0, res[9:2]});
            rd(8'h08, c[0] ? {24'h0, res[7:0]} : {24'h0, res[1:0], 6'h0});
            rd(8'h10, 32'h3);
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, 8'h10, 32'h3);
            rd(8'h10, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 8'h00, k == 0 ? 32'h0 : (k == 1 ? 32'hE0 : 32'h10));
            atrf_source_model_inst.pulse(k == 2 ? 1 : 0, 10);
            chk(nStart, 13);
        end
        apb(1'b1, 8'h0C, 32'h1);
        wait_idle(32'h0);
        chk(nStart, 14);
        tally_and_finish;
    end
endmodule

// file: test/atrf_checker.sv
// Port-level assertions for the converter trigger and result block.
// Sees only top ports; select, mask and busy are rebuilt from traffic.
`timescale 1ns/100ps
module atrf_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Source, converter and interrupt
    input wire logic        captureUnitOne,
    input wire logic        convStart,
    input wire logic        convDone,
    input wire logic        irq
);
    logic [3:0] selH;
    logic       maskH;
    logic       busyH;
    logic       wr;
    assign wr = psel && penable && pready && pwrite;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            selH <= 4'h0;
            maskH <= 1'b0;
            busyH <= 1'b0;
        end else begin
            if (wr && paddr == 8'h00) selH <= pwdata[7:4];
            if (wr && paddr == 8'h14) maskH <= pwdata[0];
            busyH <= convStart || (busyH && !convDone);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
        else $error("unmapped access not refused");
    a_err_data_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");
    a_nibble_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[3:0] == 4'h0)
        else $error("control low nibble not zero");
    a_start_single: assert property (convStart |=> !convStart)
        else $error("start pulse too long");
    a_edge_start: assert property (selH == 4'h1 && !busyH && $rose(captureUnitOne) |-> ##[1:4] convStart)
        else $error("selected edge did not start");
    a_level_quiet: assert property (captureUnitOne [*8] |-> !convStart)
        else $error("steady level restarted");
    a_done_irq: assert property (busyH && convDone && maskH |=> ##1 irq)
        else $error("done did not raise irq");
    c_start: cover property (convStart);
    c_done: cover property (busyH && convDone);
    c_err: cover property (pslverr);
endmodule
bind atrf_adc_trigger_result atrf_checker atrf_checker_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .captureUnitOne(captureUnitOne), .convStart(convStart), .convDone(convDone), .irq(irq));

// file: test/atrf_source_model.sv
// Trigger peripherals and the analog converter core beside the block.
// The converter answers every start after a fixed latency.
`timescale 1ns/100ps
module atrf_source_model #(
    parameter int LAT = 6
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // Sources, bit n is select code n+1
    output logic [12:0]    srcLines,
    // Converter core
    input wire logic       convStart,
    input wire logic [9:0] resultIn,
    output logic           convDone,
    output logic [9:0]     conversionResult
);
    logic [LAT-1:0] pipe;
    initial srcLines = 13'h0;
    // Held well past two cycles each way so the synchroniser sees it
    task automatic pulse(input int idx, input int len);
        @(posedge mclk);
        srcLines[idx] <= 1'b1;
        repeat (len) @(posedge mclk);
        srcLines[idx] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pipe <= '0;
            convDone <= 1'b0;
            conversionResult <= 10'h000;
        end else begin
            pipe <= {pipe[LAT-2:0], convStart};
            convDone <= pipe[LAT-1];
            // Result bus toggles outside done so stale data never looks valid
            conversionResult <= pipe[LAT-1] ? resultIn : ~conversionResult;
        end
    end
endmodule

// file: verilog/atrf_adc_trigger_result.sv
// Trigger selection, conversion flag and result formatting for a 10-bit converter.
// Assumes the analog converter answers convStart with a one-cycle convDone and
// valid conversionResult on the same clock; trigger sources may be asynchronous.
// Software owns the acquisition wait before any start; nothing here times it.
`timescale 1ns/100ps

module atrf_adc_trigger_result #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Trigger sources
    input  wire logic              captureUnitOne,
    input  wire logic              captureUnitTwo,
    input  wire logic              timerZeroRollover,
    input  wire logic              timerOneRollover,
    input  wire logic              timerTwoPeriodHit,
    input  wire logic              comparatorOneSyncedOut,
    input  wire logic              comparatorTwoSyncedOut,
    input  wire logic              logicCellOneOutput,
    input  wire logic              logicCellTwoOutput,
    input  wire logic              logicCellThreeOutput,
    input  wire logic              logicCellFourOutput,
    input  wire logic              timerFourPeriodHit,
    input  wire logic              timerSixPeriodHit,
    // Converter core
    output logic                   convStart,
    input  wire logic              convDone,
    input  wire logic [9:0]        conversionResult,
    // Interrupt
    output logic                   irq
);

    // One slot per select code, dead codes included, so the mux index never runs off the end
    localparam int SRC_N = 2 ** atrf_pkg::TRIG_SEL_W;

    // Register state
    logic [3:0]             triggerSourceSelect;
    logic                   resultJustifySelect;
    logic                   convBusy;
    logic [7:0]             resultHighByte;
    logic [7:0]             resultLowByte;
    logic [1:0]             irqStatus;
    logic [1:0]             irqMask;

    // Bus decode
    logic                   setupPhase;
    logic                   writeTaken;
    logic [7:0]             regAddr;
    logic                   addrHit;
    logic [31:0]            next_prdata;

    // Trigger path
    logic [SRC_N-1:0]       sourceVec;
    logic [SRC_N-1:0]       risePulseVec;
    logic                   trigPulse;
    logic                   swGo;
    logic                   startReq;
    logic                   busyClears;
    logic                   resultLoad;
    logic                   swHighWrite;
    logic                   swLowWrite;
    logic [7:0]             next_resultHigh;
    logic [7:0]             next_resultLow;
    logic [1:0]             irqEvents;

    assign regAddr    = 8'(paddr);
    assign setupPhase = psel & ~penable;
    assign writeTaken = psel & penable & pwrite & pready;

    // Source table indexed by the select code; codes 0, 14 and 15 give a dead line
    assign sourceVec = {
        1'b0,                      // 15 reserved
        1'b0,                      // 14 reserved
        timerSixPeriodHit,         // 13
        timerFourPeriodHit,        // 12
        logicCellFourOutput,       // 11
        logicCellThreeOutput,      // 10
        logicCellTwoOutput,        // 9
        logicCellOneOutput,        // 8
        comparatorTwoSyncedOut,    // 7
        comparatorOneSyncedOut,    // 6
        timerTwoPeriodHit,         // 5
        timerOneRollover,          // 4
        timerZeroRollover,         // 3
        captureUnitTwo,            // 2
        captureUnitOne,            // 1
        1'b0                       // 0 no trigger
    };

    // Each line is synchronised and edge-detected on its own, ahead of the select mux:
    // the mux never sees an asynchronous level, and a select change while a source
    // sits high cannot fake an edge. The three dead codes cost three idle synchronisers that fold away.
    generate
        for (genvar i = 0; i < SRC_N; i++) begin : g_src
            atrf_edge_sync #(
                .STAGES (atrf_pkg::SYNC_STAGES)
            ) atrf_edge_sync_inst (
                .mclk      (mclk),
                .sys_rst   (sys_rst),
                .din       (sourceVec[i]),
                .risePulse (risePulseVec[i])
            );
        end
    endgenerate

    // Rollover lines are only observed here, never consumed, so their timers keep flagging
    // Status and start both see the selected pulse; starts while busy, outside the convDone cycle, are dropped later
    assign trigPulse = risePulseVec[triggerSourceSelect];

    // Trigger control register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            triggerSourceSelect <= atrf_pkg::TRIG_SEL_RESET;
        end else if (writeTaken && regAddr == atrf_pkg::OFF_TRIG_CTRL) begin
            triggerSourceSelect <= pwdata[atrf_pkg::TRIG_SEL_LSB +: atrf_pkg::TRIG_SEL_W];
        end
    end

    // Justify select lives in the conversion control register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            resultJustifySelect <= atrf_pkg::JUSTIFY_RESET;
        end else if (writeTaken && regAddr == atrf_pkg::OFF_CONV_CTRL) begin
            resultJustifySelect <= pwdata[atrf_pkg::CONV_JUSTIFY_BIT];
        end
    end

    // Conversion-in-progress flag
    assign swGo       = writeTaken && regAddr == atrf_pkg::OFF_CONV_CTRL && pwdata[atrf_pkg::CONV_BUSY_BIT];
    assign startReq   = trigPulse | swGo;
    assign busyClears = convBusy & convDone;
    assign resultLoad = busyClears;

    // A start in the completion cycle wins and begins the next conversion
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            convBusy <= 1'b0;
        end else if (startReq && (!convBusy || convDone)) begin
            convBusy <= 1'b1;
        end else if (busyClears) begin
            convBusy <= 1'b0;
        end
    end

    // Starts while busy are dropped unless convDone comes in the same cycle: the core cannot take a second request
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            convStart <= 1'b0;
        end else begin
            convStart <= startReq & (~convBusy | convDone);
        end
    end

    // Result formatting
    always_comb begin
        if (resultJustifySelect) begin
            next_resultHigh = {6'h00, conversionResult[9:8]};
            next_resultLow  = conversionResult[7:0];
        end else begin
            next_resultHigh = conversionResult[9:2];
            next_resultLow  = {conversionResult[1:0], 6'h00};
        end
    end

    assign swHighWrite = writeTaken && regAddr == atrf_pkg::OFF_RESULT_HIGH;
    assign swLowWrite  = writeTaken && regAddr == atrf_pkg::OFF_RESULT_LOW;

    // Unknown after power-up; a read before the first load or write returns garbage
    // No reset: contents survive sys_rst; hardware load beats a software write
    always_ff @(posedge mclk) begin
        if (resultLoad) begin
            resultHighByte <= next_resultHigh;
        end else if (swHighWrite) begin
            resultHighByte <= pwdata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (resultLoad) begin
            resultLowByte <= next_resultLow;
        end else if (swLowWrite) begin
            resultLowByte <= pwdata[7:0];
        end
    end

    assign irqEvents = {trigPulse, resultLoad};

    // Interrupt status: write one to clear, a new event in the same cycle wins
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus <= atrf_pkg::IRQ_RESET;
        end else begin
            if (writeTaken && regAddr == atrf_pkg::OFF_IRQ_STATUS) begin
                irqStatus <= (irqStatus & ~pwdata[atrf_pkg::IRQ_W-1:0]) | irqEvents;
            end else begin
                irqStatus <= irqStatus | irqEvents;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irqMask <= atrf_pkg::IRQ_RESET;
        end else if (writeTaken && regAddr == atrf_pkg::OFF_IRQ_MASK) begin
            irqMask <= pwdata[atrf_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end

    // Read mux, sampled in the setup phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        addrHit     = 1'b1;
        case (regAddr)
            atrf_pkg::OFF_TRIG_CTRL: begin
                next_prdata[7:0] = {triggerSourceSelect, 4'h0};
            end
            atrf_pkg::OFF_RESULT_HIGH: begin
                next_prdata[7:0] = resultHighByte;
            end
            atrf_pkg::OFF_RESULT_LOW: begin
                next_prdata[7:0] = resultLowByte;
            end
            atrf_pkg::OFF_CONV_CTRL: begin
                next_prdata[atrf_pkg::CONV_JUSTIFY_BIT] = resultJustifySelect;
                next_prdata[atrf_pkg::CONV_BUSY_BIT]    = convBusy;
            end
            atrf_pkg::OFF_IRQ_STATUS: begin
                next_prdata[atrf_pkg::IRQ_W-1:0] = irqStatus;
            end
            atrf_pkg::OFF_IRQ_MASK: begin
                next_prdata[atrf_pkg::IRQ_W-1:0] = irqMask;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // One access cycle: ready rises for the cycle after setup only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPhase;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= ~addrHit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule

// file: verilog/atrf_edge_sync.sv
// Synchroniser plus rising-edge detector for one trigger line.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/100ps

module atrf_edge_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Raw and detected
    input  wire logic din,
    output logic      risePulse
);

    logic [STAGES-1:0] syncChain;
    logic              prevLevel;

    // First stage feeds only the next stage
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            syncChain <= '0;
        end else begin
            syncChain <= {syncChain[STAGES-2:0], din};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= syncChain[STAGES-1];
        end
    end

    // One cycle per low-to-high change; a steady high gives nothing
    assign risePulse = syncChain[STAGES-1] & ~prevLevel;

endmodule

// file: verilog/atrf_pkg.sv
// Constants for the converter trigger and result formatting block.
// Assumes a 32-bit APB with one aligned word per register.
package atrf_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_TRIG_CTRL   = 8'h00;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
    localparam logic [7:0] OFF_RESULT_LOW  = 8'h08;
    localparam logic [7:0] OFF_CONV_CTRL   = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h14;

    // Trigger source field of the trigger control register
    localparam int         TRIG_SEL_LSB    = 4;
    localparam int         TRIG_SEL_W      = 4;
    localparam logic [3:0] TRIG_NONE       = 4'h0;
    localparam logic [3:0] TRIG_LAST_VALID = 4'hD;
    localparam logic [3:0] TRIG_SEL_RESET  = 4'h0;

    // Conversion control register fields
    localparam int         CONV_BUSY_BIT    = 0;
    localparam int         CONV_JUSTIFY_BIT = 7;
    localparam logic       JUSTIFY_RESET    = 1'b0;

    // Interrupt status and mask fields
    localparam int         IRQ_DONE_BIT   = 0;
    localparam int         IRQ_TRIG_BIT   = 1;
    localparam int         IRQ_W          = 2;
    localparam logic [1:0] IRQ_RESET      = 2'h0;

    // Result layout
    localparam int         RESULT_W       = 10;

    // Trigger synchroniser depth
    localparam int         SYNC_STAGES    = 2;

endpackage
